/* File: swt_pkg.sv */
// Shared constants and types for the sweep trace noise reduction block.
package swt_pkg;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] AVG_FACTOR_MAX = 10'h3E7;
	localparam logic [CNT_W-1:0] AVG_COUNT_START = 10'h001;
	localparam int RECIP_BITS = 20;
	localparam int RECIP_STEP_W = 5;
	localparam logic [RECIP_STEP_W-1:0] RECIP_LAST_STEP = 5'h14;
	localparam int PCT_W = 7;
	localparam logic [PCT_W-1:0] SMOOTH_AP_MAX_PCT = 7'h14;
	localparam int PCT_FULL = 100;
	localparam int HZ_W = 16;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_3000 = 16'h0BB8;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_1000 = 16'h03E8;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_300 = 16'h012C;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_100 = 16'h0064;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_30 = 16'h001E;
	localparam logic [HZ_W-1:0] IF_BANDWIDTH_SELECT_CMD_HZ_10 = 16'h000A;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_3000 = 3'h0;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_1000 = 3'h1;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_300 = 3'h2;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_100 = 3'h3;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_30 = 3'h4;
	localparam logic [2:0] IF_BANDWIDTH_SELECT_CMD_SEL_10 = 3'h5;

	typedef enum logic [3:0] {
		AF_NONE = 4'h1,
		AF_AVG_FACTOR = 4'h2,
		AF_SMOOTH_AP = 4'h4,
		AF_IF_BW = 4'h8
	} swt_active_fn_t;

	typedef enum logic [1:0] {
		DIV_IDLE = 2'h1,
		DIV_RUN = 2'h2
	} swt_div_state_t;
endpackage

/* File: swt_avg_mem.sv */
// Storage of the previous complex average, one word per channel and trace point.
`timescale 1ns/1ps
module swt_avg_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 802,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule // swt_avg_mem

/* File: swt_noise_reduction.sv */
// Sweep averaging, smoothing settings and IF bandwidth selection for the trace path.
// Summary of operation
// R1: Restart clears average, count 1 next sweep.
// R2: Factor accepted up to 999, becomes active.
// R3: New average = S/F + (1-1/F)*old.
// R4: Divisor is count, saturating at factor.
// R5: Per-channel averaging enable via on/off.
// R6: Data-affecting setting change resets count to 1.
// R7: Report averaging active and sweep count.
// R8: Aperture in percent, also in stimulus units.
// R9: Aperture is group delay aperture only smoothed.
// R10: Per-channel smoothing enable and active status.
// R11: IF bandwidth from six values, reported.
// R12: Other bandwidth requests round down; requests below 10 Hz are set to 10 Hz instead.
// R13: Smoothing uses one sweep, aperture max 20%.
// R14: Complex average kept per point, channel.
`timescale 1ns/1ps
module swt_noise_reduction
	import swt_pkg::*;
#(
	parameter int NUM_CH = 2,
	parameter int POINTS = 401,
	parameter int DW = 16,
	parameter int IW = $clog2(POINTS),
	parameter int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [CHW-1:0] active_ch_in,
	input wire logic average_restart_cmd_in,
	input wire logic average_factor_cmd_in,
	input wire logic [CNT_W-1:0] average_factor_in,
	input wire logic average_enable_cmd_in,
	input wire logic average_disable_cmd_in,
	input wire logic settings_change_in,
	input wire logic smooth_aperture_cmd_in,
	input wire logic [PCT_W-1:0] smooth_aperture_pct_in,
	input wire logic smooth_enable_cmd_in,
	input wire logic smooth_disable_cmd_in,
	input wire logic [31:0] span_hz_in,
	input wire logic if_bandwidth_select_cmd_in,
	input wire logic [HZ_W-1:0] if_bandwidth_req_in,
	input wire logic sweep_start_in,
	input wire logic [CHW-1:0] sweep_ch_in,
	input wire logic sample_valid_in,
	input wire logic [CHW-1:0] sample_ch_in,
	input wire logic [IW-1:0] sample_idx_in,
	input wire logic signed [DW-1:0] sample_re_in,
	input wire logic signed [DW-1:0] sample_im_in,
	output logic sample_ready_out,
	output logic avg_valid_out,
	output logic [CHW-1:0] avg_ch_out,
	output logic [IW-1:0] avg_idx_out,
	output logic signed [DW-1:0] avg_re_out,
	output logic signed [DW-1:0] avg_im_out,
	output logic [NUM_CH-1:0] avg_active_out,
	output logic [NUM_CH-1:0][CNT_W-1:0] sweep_count_out,
	output logic [CNT_W-1:0] average_factor_out,
	output logic [3:0] active_function_out,
	output logic [PCT_W-1:0] smooth_aperture_pct_out,
	output logic [31:0] smooth_aperture_hz_out,
	output logic [IW:0] smooth_aperture_points_out,
	output logic [NUM_CH-1:0] smooth_active_out,
	output logic [PCT_W-1:0] group_delay_aperture_pct_out,
	output logic group_delay_aperture_valid_out,
	output logic [2:0] if_bandwidth_sel_out,
	output logic [HZ_W-1:0] if_bandwidth_hz_out
);
	localparam int DEPTH = NUM_CH * POINTS;
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW-1:0] point_addr(input logic [CHW-1:0] ch, input logic [IW-1:0] idx);
		point_addr = AW'(ch * POINTS + idx);
	endfunction

	// Written as old + (S - old) / F, which is the same weighting with one multiply.
	function automatic logic signed [DW-1:0] avg_step(input logic signed [DW-1:0] prev,
			input logic signed [DW-1:0] meas, input logic [RECIP_BITS:0] recip);
		logic signed [DW:0] diff;
		logic signed [DW+RECIP_BITS+2:0] prod;
		diff = {meas[DW-1], meas} - {prev[DW-1], prev};
		prod = diff * $signed({1'b0, recip});
		avg_step = DW'(prev + (prod >>> RECIP_BITS));
	endfunction

	logic [NUM_CH-1:0][CNT_W-1:0] cnt_r;
	logic [NUM_CH-1:0][RECIP_BITS:0] recip_r;
	logic [NUM_CH-1:0] pend_r;
	logic [NUM_CH-1:0] avg_en_r;
	logic [NUM_CH-1:0] smooth_en_r;
	logic [CNT_W-1:0] fact_r;
	swt_active_fn_t afn_r;
	logic [PCT_W-1:0] ap_pct_r;
	logic [2:0] bw_sel_r;
	logic [HZ_W-1:0] bw_hz_r;
	swt_div_state_t div_st_r;
	logic [CHW-1:0] div_ch_r;
	logic [CNT_W-1:0] div_f_r;
	logic [CNT_W:0] div_rem_r;
	logic [RECIP_BITS:0] div_q_r;
	logic [RECIP_STEP_W-1:0] div_step_r;
	logic p1_valid_r;
	logic [CHW-1:0] p1_ch_r;
	logic [IW-1:0] p1_idx_r;
	logic signed [DW-1:0] p1_re_r;
	logic signed [DW-1:0] p1_im_r;
	logic [2*DW-1:0] prev_w;

	wire logic accept_w = sample_valid_in & sample_ready_out;
	wire logic [CNT_W-1:0] cnt_cur_w = cnt_r[sweep_ch_in];
	wire logic [CNT_W-1:0] cnt_next_w = pend_r[sweep_ch_in] ? AVG_COUNT_START : // R1 R6
		(cnt_cur_w < fact_r) ? CNT_W'(cnt_cur_w + 1'b1) : fact_r; // R4
	wire logic [CNT_W-1:0] fact_clamp_w = (average_factor_in > AVG_FACTOR_MAX) ? AVG_FACTOR_MAX :
		(average_factor_in == '0) ? AVG_COUNT_START : average_factor_in; // R2
	wire logic [PCT_W-1:0] ap_clamp_w = (smooth_aperture_pct_in > SMOOTH_AP_MAX_PCT) ?
		SMOOTH_AP_MAX_PCT : smooth_aperture_pct_in; // R13
	wire logic [CNT_W:0] div_sh_w = {div_rem_r[CNT_W-1:0], div_step_r == RECIP_LAST_STEP};
	wire logic div_ge_w = div_sh_w >= {1'b0, div_f_r};
	wire logic signed [DW-1:0] prev_re_w = prev_w[2*DW-1:DW];
	wire logic signed [DW-1:0] prev_im_w = prev_w[DW-1:0];
	wire logic p1_avg_w = avg_en_r[p1_ch_r];
	// A divisor of one takes the measurement as it is, so unwritten or stale memory never
	// leaks into a restarted average.
	wire logic p1_mix_w = p1_avg_w & ~recip_r[p1_ch_r][RECIP_BITS]; // R1
	wire logic signed [DW-1:0] new_re_w = p1_mix_w ? avg_step(prev_re_w, p1_re_r, recip_r[p1_ch_r]) :
		p1_re_r; // R3 R14
	wire logic signed [DW-1:0] new_im_w = p1_mix_w ? avg_step(prev_im_w, p1_im_r, recip_r[p1_ch_r]) :
		p1_im_r; // R3 R14
	wire logic [2:0] bw_sel_w = (if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_3000) ? IF_BANDWIDTH_SELECT_CMD_SEL_3000 :
		(if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_1000) ? IF_BANDWIDTH_SELECT_CMD_SEL_1000 :
		(if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_300) ? IF_BANDWIDTH_SELECT_CMD_SEL_300 :
		(if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_100) ? IF_BANDWIDTH_SELECT_CMD_SEL_100 :
		(if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_30) ? IF_BANDWIDTH_SELECT_CMD_SEL_30 : IF_BANDWIDTH_SELECT_CMD_SEL_10; // R11 R12
	wire logic [HZ_W-1:0] bw_hz_w = (bw_sel_w == IF_BANDWIDTH_SELECT_CMD_SEL_3000) ? IF_BANDWIDTH_SELECT_CMD_HZ_3000 :
		(bw_sel_w == IF_BANDWIDTH_SELECT_CMD_SEL_1000) ? IF_BANDWIDTH_SELECT_CMD_HZ_1000 :
		(bw_sel_w == IF_BANDWIDTH_SELECT_CMD_SEL_300) ? IF_BANDWIDTH_SELECT_CMD_HZ_300 :
		(bw_sel_w == IF_BANDWIDTH_SELECT_CMD_SEL_100) ? IF_BANDWIDTH_SELECT_CMD_HZ_100 :
		(bw_sel_w == IF_BANDWIDTH_SELECT_CMD_SEL_30) ? IF_BANDWIDTH_SELECT_CMD_HZ_30 : IF_BANDWIDTH_SELECT_CMD_HZ_10; // R11

	swt_avg_mem #(.WIDTH(2 * DW), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.wr_en_in(p1_valid_r & p1_avg_w), // R14
		.wr_addr_in(point_addr(p1_ch_r, p1_idx_r)),
		.wr_data_in({new_re_w, new_im_w}),
		.rd_addr_in(point_addr(sample_ch_in, sample_idx_in)),
		.rd_data_out(prev_w)
	);

	// Samples are held off while the reciprocal of the new divisor is still being formed.
	assign sample_ready_out = (div_st_r == DIV_IDLE);
	assign avg_active_out = avg_en_r; // R7
	assign sweep_count_out = cnt_r; // R7
	assign average_factor_out = fact_r;
	assign active_function_out = afn_r;
	assign smooth_aperture_pct_out = ap_pct_r;
	assign smooth_aperture_hz_out = 32'((64'(span_hz_in) * ap_pct_r) / PCT_FULL); // R8
	assign smooth_aperture_points_out = (IW+1)'((POINTS * ap_pct_r) / PCT_FULL); // R13
	assign smooth_active_out = smooth_en_r; // R10
	assign group_delay_aperture_valid_out = smooth_en_r[active_ch_in]; // R9
	assign group_delay_aperture_pct_out = smooth_en_r[active_ch_in] ? ap_pct_r : '0; // R9
	assign if_bandwidth_sel_out = bw_sel_r;
	assign if_bandwidth_hz_out = bw_hz_r;

	// A pending restart set in the same cycle as a sweep start survives into the next sweep.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pend_r <= '1;
			cnt_r <= '0;
			avg_en_r <= '0;
			smooth_en_r <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (sweep_start_in && sweep_ch_in == CHW'(c)) begin
					cnt_r[c] <= cnt_next_w; // R4
					pend_r[c] <= 1'b0;
				end
				// Turning averaging on restarts the count as well, since the start of averaging
				// begins at one.
				if (settings_change_in || (active_ch_in == CHW'(c) &&
						(average_restart_cmd_in || average_enable_cmd_in ||
						average_disable_cmd_in))) begin
					pend_r[c] <= 1'b1; // R1 R6
				end
				if (active_ch_in == CHW'(c) && average_enable_cmd_in) begin
					avg_en_r[c] <= 1'b1; // R5
				end else if (active_ch_in == CHW'(c) && average_disable_cmd_in) begin
					avg_en_r[c] <= 1'b0; // R5
				end
				if (active_ch_in == CHW'(c) && smooth_enable_cmd_in) begin
					smooth_en_r[c] <= 1'b1; // R10
				end else if (active_ch_in == CHW'(c) && smooth_disable_cmd_in) begin
					smooth_en_r[c] <= 1'b0; // R10
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fact_r <= AVG_COUNT_START;
			afn_r <= AF_NONE;
			ap_pct_r <= '0;
			bw_sel_r <= IF_BANDWIDTH_SELECT_CMD_SEL_3000;
			bw_hz_r <= IF_BANDWIDTH_SELECT_CMD_HZ_3000;
		end else begin
			if (average_factor_cmd_in) begin
				fact_r <= fact_clamp_w; // R2
				afn_r <= AF_AVG_FACTOR; // R2
			end else if (smooth_aperture_cmd_in) begin
				ap_pct_r <= ap_clamp_w; // R8 R13
				afn_r <= AF_SMOOTH_AP;
			end else if (if_bandwidth_select_cmd_in) begin
				bw_sel_r <= bw_sel_w; // R12
				bw_hz_r <= bw_hz_w; // R11
				afn_r <= AF_IF_BW;
			end
		end
	end

	// The reciprocal is found bit by bit so that no wide divider sits in the sample path.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			div_st_r <= DIV_IDLE;
			div_ch_r <= '0;
			div_f_r <= AVG_COUNT_START;
			div_rem_r <= '0;
			div_q_r <= '0;
			div_step_r <= '0;
			recip_r <= {NUM_CH{(RECIP_BITS+1)'(1) << RECIP_BITS}};
		end else begin
			case (div_st_r)
				DIV_IDLE: begin
					if (sweep_start_in) begin
						div_st_r <= DIV_RUN;
						div_ch_r <= sweep_ch_in;
						div_f_r <= cnt_next_w; // R4
						div_rem_r <= '0;
						div_q_r <= '0;
						div_step_r <= RECIP_LAST_STEP;
					end
				end
				DIV_RUN: begin
					div_rem_r <= div_ge_w ? div_sh_w - {1'b0, div_f_r} : div_sh_w;
					div_q_r <= {div_q_r[RECIP_BITS-1:0], div_ge_w};
					div_step_r <= div_step_r - 1'b1;
					if (div_step_r == '0) begin
						recip_r[div_ch_r] <= {div_q_r[RECIP_BITS-1:0], div_ge_w}; // R3
						div_st_r <= DIV_IDLE;
					end
				end
				default: div_st_r <= DIV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			p1_valid_r <= 1'b0;
			p1_ch_r <= '0;
			p1_idx_r <= '0;
			p1_re_r <= '0;
			p1_im_r <= '0;
			avg_valid_out <= 1'b0;
			avg_ch_out <= '0;
			avg_idx_out <= '0;
			avg_re_out <= '0;
			avg_im_out <= '0;
		end else begin
			p1_valid_r <= accept_w;
			p1_ch_r <= sample_ch_in;
			p1_idx_r <= sample_idx_in;
			p1_re_r <= sample_re_in;
			p1_im_r <= sample_im_in;
			avg_valid_out <= p1_valid_r;
			avg_ch_out <= p1_ch_r;
			avg_idx_out <= p1_idx_r;
			avg_re_out <= new_re_w; // R3
			avg_im_out <= new_im_w; // R3
		end
	end

	chk_restart_count: assert property (@(posedge clk_in) disable iff (reset_in) // R1
		sweep_start_in && sample_ready_out && pend_r[sweep_ch_in]
		|=> cnt_r[$past(sweep_ch_in)] == AVG_COUNT_START)
		else $error("Sweep count not restarted at 1.");
	chk_factor_range: assert property (@(posedge clk_in) disable iff (reset_in) // R2
		average_factor_cmd_in |=> fact_r <= AVG_FACTOR_MAX && fact_r != '0
		&& active_function_out == AF_AVG_FACTOR)
		else $error("Averaging factor out of range or not active.");
	chk_first_sweep: assert property (@(posedge clk_in) disable iff (reset_in) // R3
		accept_w && avg_en_r[sample_ch_in] && cnt_r[sample_ch_in] == AVG_COUNT_START
		&& recip_r[sample_ch_in] == (RECIP_BITS+1)'(1) << RECIP_BITS
		|=> ##1 avg_valid_out && avg_re_out == $past(sample_re_in, 2))
		else $error("First averaged sweep differs from measurement.");
	chk_count_hold: assert property (@(posedge clk_in) disable iff (reset_in) // R4
		sweep_start_in && !pend_r[sweep_ch_in] && cnt_r[sweep_ch_in] == fact_r
		&& !average_factor_cmd_in |=> cnt_r[$past(sweep_ch_in)] == fact_r)
		else $error("Sweep count moved past the averaging factor.");
	chk_avg_enable: assert property (@(posedge clk_in) disable iff (reset_in) // R5
		average_enable_cmd_in |=> avg_active_out[$past(active_ch_in)])
		else $error("Averaging enable not taken for active channel.");
	chk_settings_reset: assert property (@(posedge clk_in) disable iff (reset_in) // R6
		settings_change_in |=> pend_r == {NUM_CH{1'b1}})
		else $error("Setting change did not force a count restart.");
	chk_count_report: assert property (@(posedge clk_in) disable iff (reset_in) // R7
		sweep_start_in && sample_ready_out
		|=> sweep_count_out[$past(sweep_ch_in)] != '0)
		else $error("Reported sweep count is zero after a sweep start.");
	chk_gd_aperture: assert property (@(posedge clk_in) disable iff (reset_in) // R9
		!smooth_active_out[active_ch_in] |-> group_delay_aperture_pct_out == '0)
		else $error("Group delay aperture shown without smoothing.");
	chk_aperture_cap: assert property (@(posedge clk_in) disable iff (reset_in) // R13
		smooth_aperture_cmd_in |=> smooth_aperture_pct_out <= SMOOTH_AP_MAX_PCT
		&& smooth_aperture_points_out <= (IW+1)'(POINTS))
		else $error("Smoothing aperture above its cap.");
	chk_if_bandwidth_select_cmd_round: assert property (@(posedge clk_in) disable iff (reset_in) // R12
		if_bandwidth_select_cmd_in && if_bandwidth_req_in >= IF_BANDWIDTH_SELECT_CMD_HZ_10
		|=> if_bandwidth_hz_out <= $past(if_bandwidth_req_in))
		else $error("IF bandwidth not rounded downward.");
endmodule // swt_noise_reduction

/* File: swt_rx_model.sv */
// Behavioural receiver model that starts sweeps and streams measured points.
`timescale 1ns/1ps
module swt_rx_model #(
	parameter int POINTS = 10,
	parameter int DW = 16,
	parameter int IW = 4
) (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic ch_in,
	input wire logic [15:0] base_in,
	input wire logic ready_in,
	output logic busy_out,
	output logic sweep_start_out,
	output logic sweep_ch_out,
	output logic sample_valid_out,
	output logic sample_ch_out,
	output logic [IW-1:0] sample_idx_out,
	output logic signed [DW-1:0] sample_re_out,
	output logic signed [DW-1:0] sample_im_out
);
	initial begin
		busy_out = 0;
		sweep_start_out = 0;
		sweep_ch_out = 0;
		sample_valid_out = 0;
		sample_ch_out = 0;
		sample_idx_out = '0;
		sample_re_out = '0;
		sample_im_out = '0;
		forever begin
			@(posedge clk_in);
			if (go_in) begin
				#1;
				busy_out = 1;
				sweep_start_out = 1;
				sweep_ch_out = ch_in;
				sample_ch_out = ch_in;
				@(posedge clk_in);
				while (!ready_in) @(posedge clk_in);
				#1;
				sweep_start_out = 0;
				@(posedge clk_in);
				while (!ready_in) @(posedge clk_in);
				for (int i = 0; i < POINTS; i++) begin
					#1;
					sample_valid_out = 1;
					sample_idx_out = IW'(i);
					sample_re_out = DW'(int'(base_in) + i);
					sample_im_out = DW'(-int'(base_in) - 2 * i);
					@(posedge clk_in);
					while (!ready_in) @(posedge clk_in);
				end
				#1;
				// Released data lines show the inverse so a stale value never looks valid.
				sample_valid_out = 0;
				sample_idx_out = ~sample_idx_out;
				sample_re_out = ~sample_re_out;
				sample_im_out = ~sample_im_out;
				busy_out = 0;
			end
		end
	end
endmodule // swt_rx_model

/* File: tb_top.sv */
// Self-checking bench for the sweep trace noise reduction block.
`timescale 1ns/1ps
module tb_top;
	import swt_pkg::*;
	localparam int NP = 10;
	logic clk_in = 0, reset_in = 1, ach = 0, go = 0, wch = 0;
	logic rs_c = 0, fa_c = 0, on_c = 0, of_c = 0, ch_c = 0, ap_c = 0, so_c = 0, sf_c = 0, bw_c = 0;
	logic [CNT_W-1:0] fac = '0;
	logic [PCT_W-1:0] ap = '0;
	logic [HZ_W-1:0] bw = '0;
	logic [15:0] base = '0;
	logic ready, st, sch, sv, sc, busy, avv, avc, gdv;
	logic [3:0] si, avi, afo;
	logic signed [15:0] sre, sim, avre, avim;
	logic [1:0] aact, sact;
	logic [1:0][CNT_W-1:0] cnt;
	logic [CNT_W-1:0] fo;
	logic [PCT_W-1:0] apo, gdp;
	logic [31:0] aphz;
	logic [4:0] appt;
	logic [2:0] bsel;
	logic [HZ_W-1:0] bhz;
	longint old_re [2][NP], old_im [2][NP];
	logic [1:0] en = '0, pend = 2'h3;
	int ecnt [2] = '{0, 0};
	int ef = 1, fail_count = 0, n_tests = 0, nav = 0;
	logic [HZ_W-1:0] rq [13] = '{16'h1388, 16'h0BB8, 16'h0BB7, 16'h03E8, 16'h03E7, 16'h012C,
		16'h012B, 16'h0064, 16'h0032, 16'h001E, 16'h001D, 16'h000A, 16'h0005};
	int esel [13] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 5};
	logic [HZ_W-1:0] hzt [6] = '{IF_BANDWIDTH_SELECT_CMD_HZ_3000, IF_BANDWIDTH_SELECT_CMD_HZ_1000, IF_BANDWIDTH_SELECT_CMD_HZ_300, IF_BANDWIDTH_SELECT_CMD_HZ_100,
		IF_BANDWIDTH_SELECT_CMD_HZ_30, IF_BANDWIDTH_SELECT_CMD_HZ_10};
	swt_noise_reduction #(.NUM_CH(2), .POINTS(NP), .DW(16)) DUT (.clk_in(clk_in),
		.reset_in(reset_in), .active_ch_in(ach), .average_restart_cmd_in(rs_c),
		.average_factor_cmd_in(fa_c), .average_factor_in(fac), .average_enable_cmd_in(on_c),
		.average_disable_cmd_in(of_c), .settings_change_in(ch_c), .smooth_aperture_cmd_in(ap_c),
		.smooth_aperture_pct_in(ap), .smooth_enable_cmd_in(so_c), .smooth_disable_cmd_in(sf_c),
		.span_hz_in(32'h000F4240), .if_bandwidth_select_cmd_in(bw_c), .if_bandwidth_req_in(bw),
		.sweep_start_in(st), .sweep_ch_in(sch), .sample_valid_in(sv), .sample_ch_in(sc),
		.sample_idx_in(si), .sample_re_in(sre), .sample_im_in(sim), .sample_ready_out(ready),
		.avg_valid_out(avv), .avg_ch_out(avc), .avg_idx_out(avi), .avg_re_out(avre),
		.avg_im_out(avim), .avg_active_out(aact), .sweep_count_out(cnt),
		.average_factor_out(fo), .active_function_out(afo), .smooth_aperture_pct_out(apo),
		.smooth_aperture_hz_out(aphz), .smooth_aperture_points_out(appt),
		.smooth_active_out(sact), .group_delay_aperture_pct_out(gdp),
		.group_delay_aperture_valid_out(gdv), .if_bandwidth_sel_out(bsel),
		.if_bandwidth_hz_out(bhz));
	swt_rx_model #(.POINTS(NP), .DW(16), .IW(4)) rx (.clk_in(clk_in), .go_in(go), .ch_in(wch),
		.base_in(base), .ready_in(ready), .busy_out(busy), .sweep_start_out(st),
		.sweep_ch_out(sch), .sample_valid_out(sv), .sample_ch_out(sc), .sample_idx_out(si),
		.sample_re_out(sre), .sample_im_out(sim));
	initial forever #2 clk_in = ~clk_in;
	task automatic report_and_stop;
		if (fail_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	function automatic longint nxt(input longint o, input longint s, input int f);
		return o + (((s - o) * ((1 << 20) / f)) >>> 20);
	endfunction
	// Command pulses last one cycle; outputs are read once the answer has landed.
	task automatic pulse(input int k);
		@(posedge clk_in) #1;
		case (k)
			0: rs_c = 1;
			1: fa_c = 1;
			2: on_c = 1;
			3: of_c = 1;
			4: ch_c = 1;
			5: ap_c = 1;
			6: so_c = 1;
			7: sf_c = 1;
			default: bw_c = 1;
		endcase
		@(posedge clk_in) #1;
		{rs_c, fa_c, on_c, of_c, ch_c, ap_c, so_c, sf_c, bw_c} = '0;
		@(posedge clk_in) #1;
	endtask
	task automatic sweep(input logic c, input int b);
		int k = 0;
		ecnt[c] = pend[c] ? 1 : ((ecnt[c] < ef) ? ecnt[c] + 1 : ef);
		pend[c] = 0;
		base = 16'(b);
		wch = c;
		nav = 0;
		@(posedge clk_in) #1;
		go = 1;
		@(posedge clk_in) #1;
		go = 0;
		@(posedge clk_in) #1;
		while (busy === 1'b1 && k < 200) begin
			@(posedge clk_in) #1;
			k++;
		end
		repeat (3) @(posedge clk_in);
		#1;
		chk("sweep_done", 32'h0, 32'(busy));
		chk("avg_points", 32'(NP), 32'(nav));
		chk("sweep_count", 32'(ecnt[c]), 32'(cnt[c]));
	endtask
	always @(posedge clk_in) begin
		longint s_re, s_im, e_re, e_im;
		if (avv === 1'b1) begin
			s_re = longint'(base) + int'(avi);
			s_im = -longint'(base) - 2 * int'(avi);
			e_re = en[avc] ? nxt(old_re[avc][avi], s_re, ecnt[avc]) : s_re;
			e_im = en[avc] ? nxt(old_im[avc][avi], s_im, ecnt[avc]) : s_im;
			old_re[avc][avi] = e_re;
			old_im[avc][avi] = e_im;
			nav++;
			chk("avg_ch", 32'(wch), 32'(avc));
			chk("avg_re", 32'(e_re), 32'(avre));
			chk("avg_im", 32'(e_im), 32'(avim));
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		#1 reset_in = 0;
		chk("ready", 32'h1, 32'(ready));
		chk("factor", 32'h1, 32'(fo));
		chk("function", 32'(AF_NONE), 32'(afo));
		chk("bw_hz", 32'(IF_BANDWIDTH_SELECT_CMD_HZ_3000), 32'(bhz));
		fac = 10'h3FF;
		pulse(1);
		chk("factor", 32'(AVG_FACTOR_MAX), 32'(fo));
		chk("function", 32'(AF_AVG_FACTOR), 32'(afo));
		fac = 10'h000;
		pulse(1);
		chk("factor", 32'h1, 32'(fo));
		fac = 10'h003;
		ef = 3;
		pulse(1);
		chk("factor", 32'h3, 32'(fo));
		pulse(2);
		en[0] = 1;
		chk("avg_active", 32'h1, 32'(aact));
		for (int i = 1; i <= 4; i++) sweep(0, i * 1000);
		pulse(0);
		pend[0] = 1;
		sweep(0, 500);
		sweep(0, 700);
		ach = 1;
		pulse(2);
		en[1] = 1;
		chk("avg_active", 32'h3, 32'(aact));
		sweep(1, 900);
		pulse(4);
		pend = 2'h3;
		sweep(0, 800);
		sweep(1, 100);
		ach = 0;
		pulse(3);
		en[0] = 0;
		pend[0] = 1;
		chk("avg_active", 32'h2, 32'(aact));
		sweep(0, 300);
		ap = 7'h1E;
		pulse(5);
		chk("ap_pct", 32'(SMOOTH_AP_MAX_PCT), 32'(apo));
		chk("function", 32'(AF_SMOOTH_AP), 32'(afo));
		chk("ap_hz", 32'h00030D40, aphz);
		chk("ap_points", 32'h2, 32'(appt));
		ach = 1;
		pulse(6);
		chk("smooth_active", 32'h2, 32'(sact));
		chk("gd_valid", 32'h1, 32'(gdv));
		chk("gd_pct", 32'h14, 32'(gdp));
		ach = 0;
		@(posedge clk_in) #1;
		chk("gd_valid", 32'h0, 32'(gdv));
		chk("gd_pct", 32'h0, 32'(gdp));
		ach = 1;
		pulse(7);
		chk("smooth_active", 32'h0, 32'(sact));
		for (int i = 0; i < 13; i++) begin
			bw = rq[i];
			pulse(8);
			chk("bw_sel", 32'(esel[i]), 32'(bsel));
			chk("bw_hz", 32'(hzt[esel[i]]), 32'(bhz));
		end
		chk("function", 32'(AF_IF_BW), 32'(afo));
		report_and_stop;
	end
endmodule // tb_top
